// *** hw/balu_pkg.sv ***
package balu_pkg;

  // quarter phases, gray order
  typedef enum logic [1:0] {
    BALU_Q1 = 2'h0,
    BALU_Q2 = 2'h1,
    BALU_Q3 = 2'h3,
    BALU_Q4 = 2'h2
  } balu_phase_t;

  // arithmetic unit operations
  typedef enum logic [1:0] {
    BALU_ADD  = 2'h0,
    BALU_ADDC = 2'h1,
    BALU_AND  = 2'h2,
    BALU_BCLR = 2'h3
  } balu_aluop_t;

  // opcode fields
  localparam logic [7:0] OPC_ADD_LIT  = 8'h0f;  // upper byte
  localparam logic [7:0] OPC_AND_LIT  = 8'h0b;  // upper byte
  localparam logic [7:0] OPC_BR_CARRY = 8'he2;  // upper byte
  localparam logic [5:0] OPC_ADD_FILE = 6'h09;  // bits 15:10
  localparam logic [5:0] OPC_ADDC_FIL = 6'h08;  // bits 15:10
  localparam logic [5:0] OPC_AND_FILE = 6'h05;  // bits 15:10
  localparam logic [3:0] OPC_CLR_BIT  = 4'h9;   // bits 15:12
  localparam int         BIT_DEST     = 9;      // destination select
  localparam int         BIT_BANK     = 8;      // bank select

  // data address forming
  localparam logic [7:0] IDX_LIMIT    = 8'h5f;  // highest indexed offset
  localparam logic [7:0] ACC_SPLIT    = 8'h60;  // access bank split
  localparam logic [3:0] ACC_HI_PAGE  = 4'hf;   // upper access page
  localparam logic [3:0] ACC_LO_PAGE  = 4'h0;   // lower access page

  // status bit positions
  localparam int FLG_C  = 0;
  localparam int FLG_DC = 1;
  localparam int FLG_Z  = 2;
  localparam int FLG_OV = 3;
  localparam int FLG_N  = 4;
  localparam logic [4:0] MASK_ALL = 5'h1f;
  localparam logic [4:0] MASK_NZ  = 5'h14;

  // register byte offsets
  localparam logic [7:0] REG_CTRL   = 8'h00;  // bit0 run, bit1 extended
  localparam logic [7:0] REG_WORK   = 8'h04;  // working register
  localparam logic [7:0] REG_STATUS = 8'h08;  // flags
  localparam logic [7:0] REG_BANK   = 8'h0c;  // bank select register
  localparam logic [7:0] REG_PC     = 8'h10;  // program counter
  localparam logic [7:0] REG_INDEX  = 8'h14;  // indexed base pointer
  localparam logic [7:0] REG_INSTR  = 8'h18;  // last instruction, read only

  // bus answers and counter step
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  localparam logic [20:0] PC_STEP     = 21'h2;

endpackage : balu_pkg

// *** hw/balu_alu.sv ***
// arithmetic unit, purely combinational
module balu_alu (
  // operation select
  input  wire balu_pkg::balu_aluop_t op_i,
  input  wire logic [2:0]            bitsel_i,
  // operands
  input  wire logic [7:0]            a_i,
  input  wire logic [7:0]            b_i,
  input  wire logic                  cin_i,
  // results
  output logic      [7:0]            res_o,
  output logic      [4:0]            flags_o
);

  logic [8:0] sum;   // nine bit sum for carry out
  logic [4:0] nib;   // low nibble sum for digit carry
  logic       cin;   // carry only used by add with carry

  // sum, logic and bit clear with flag derivation
  always_comb begin
    cin = (op_i == balu_pkg::BALU_ADDC) ? cin_i : 1'b0;
    sum = 9'(a_i) + 9'(b_i) + 9'(cin);
    nib = 5'(a_i[3:0]) + 5'(b_i[3:0]) + 5'(cin);
    case (op_i)
      balu_pkg::BALU_AND:  res_o = a_i & b_i;
      balu_pkg::BALU_BCLR: res_o = b_i & ~(8'h01 << bitsel_i);
      default:             res_o = sum[7:0];
    endcase
    flags_o = 5'h00;
    flags_o[balu_pkg::FLG_N]  = res_o[7];
    flags_o[balu_pkg::FLG_Z]  = (res_o == 8'h00);
    flags_o[balu_pkg::FLG_C]  = sum[8];
    flags_o[balu_pkg::FLG_DC] = nib[4];
    flags_o[balu_pkg::FLG_OV] = (a_i[7] == b_i[7]) && (sum[7] != a_i[7]);
  end

endmodule // balu_alu

// *** hw/balu_core.sv ***
// subset execution core with register access over axi4-lite
module balu_core (
  // clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        rst_n_i,
  // instruction fetch
  input  wire logic [15:0] instr_i,
  output logic      [20:0] pc_o,
  // data memory
  output logic      [11:0] dmem_addr_o,
  output logic             dmem_rd_o,
  input  wire logic [7:0]  dmem_rdata_i,
  output logic             dmem_wr_o,
  output logic      [7:0]  dmem_wdata_o,
  // axi4-lite write
  input  wire logic [7:0]  s_axi_awaddr_i,
  input  wire logic        s_axi_awvalid_i,
  output logic             s_axi_awready_o,
  input  wire logic [31:0] s_axi_wdata_i,
  input  wire logic [3:0]  s_axi_wstrb_i,
  input  wire logic        s_axi_wvalid_i,
  output logic             s_axi_wready_o,
  output logic      [1:0]  s_axi_bresp_o,
  output logic             s_axi_bvalid_o,
  input  wire logic        s_axi_bready_i,
  // axi4-lite read
  input  wire logic [7:0]  s_axi_araddr_i,
  input  wire logic        s_axi_arvalid_i,
  output logic             s_axi_arready_o,
  output logic      [31:0] s_axi_rdata_o,
  output logic      [1:0]  s_axi_rresp_o,
  output logic             s_axi_rvalid_o,
  input  wire logic        s_axi_rready_i
);

  // whole module state
  typedef struct packed {
    balu_pkg::balu_phase_t q;        // quarter phase
    logic                  nop;      // forced no-operation cycle
    logic [15:0]           ir;       // instruction in execution
    logic [20:0]           pc;       // current fetch address
    logic [20:0]           pcinc;    // incremented counter
    logic [7:0]            working_register;     // working register
    logic [4:0]            flags;    // status flags
    logic [3:0]            bank_select_register;      // bank select register
    logic                  run;      // execution enable
    logic                  ext;      // extended set enable
    logic [11:0]           fsr2;     // indexed base pointer
    logic [7:0]            opnd;     // fetched operand
    logic [7:0]            res;      // computed result
    logic [4:0]            rflag;    // computed flags
    logic [11:0]           daddr;    // data address
    logic                  drd;      // data read strobe
    logic                  dwr;      // data write strobe
    logic [7:0]            dwdata;   // data write value
    logic                  awready;  // write address ready
    logic                  aw_got;   // write address held
    logic [7:0]            aw_addr;  // held write address
    logic                  wready;   // write data ready
    logic                  w_got;    // write data held
    logic [31:0]           wdata;    // held write data
    logic [3:0]            wstrb;    // held byte enables
    logic                  bvalid;   // write response valid
    logic [1:0]            bresp;    // write response
    logic                  arready;  // read address ready
    logic                  rvalid;   // read data valid
    logic [31:0]           rdata;    // read data
    logic [1:0]            rresp;    // read response
  } balu_core_state_t;

  balu_core_state_t s;       // registered state
  balu_core_state_t n;       // next state
  logic [7:0]       alu_res; // unit result
  logic [4:0]       alu_flg; // unit flags

  // class of an instruction word
  function automatic logic f_lit(input logic [15:0] w);
    return (w[15:8] == balu_pkg::OPC_ADD_LIT) || (w[15:8] == balu_pkg::OPC_AND_LIT);
  endfunction

  // arithmetic or logic on a file byte
  function automatic logic f_fop(input logic [15:0] w);
    return (w[15:10] == balu_pkg::OPC_ADD_FILE) || (w[15:10] == balu_pkg::OPC_ADDC_FIL)
        || (w[15:10] == balu_pkg::OPC_AND_FILE);
  endfunction

  // anything that reads a file byte
  function automatic logic f_file(input logic [15:0] w);
    return f_fop(w) || (w[15:12] == balu_pkg::OPC_CLR_BIT);
  endfunction

  // unit operation for a word
  function automatic balu_pkg::balu_aluop_t f_aluop(input logic [15:0] w);
    if (w[15:10] == balu_pkg::OPC_ADDC_FIL) begin
      return balu_pkg::BALU_ADDC;
    end else if (w[15:8] == balu_pkg::OPC_AND_LIT || w[15:10] == balu_pkg::OPC_AND_FILE) begin
      return balu_pkg::BALU_AND;
    end else if (w[15:12] == balu_pkg::OPC_CLR_BIT) begin
      return balu_pkg::BALU_BCLR;
    end else begin
      return balu_pkg::BALU_ADD;
    end
  endfunction

  // which flags a word updates
  function automatic logic [4:0] f_fmask(input logic [15:0] w);
    if (w[15:8] == balu_pkg::OPC_ADD_LIT || w[15:10] == balu_pkg::OPC_ADD_FILE
        || w[15:10] == balu_pkg::OPC_ADDC_FIL) begin
      return balu_pkg::MASK_ALL;
    end else if (w[15:8] == balu_pkg::OPC_AND_LIT || w[15:10] == balu_pkg::OPC_AND_FILE) begin
      return balu_pkg::MASK_NZ;
    end else begin
      return 5'h00;
    end
  endfunction

  // data address from bank bit, bank register and extended mode
  function automatic logic [11:0] f_addr(input logic [15:0] w, input logic [3:0] b,
                                         input logic x, input logic [11:0] base);
    if (w[balu_pkg::BIT_BANK]) begin
      return {b, w[7:0]};
    end else if (x && w[7:0] <= balu_pkg::IDX_LIMIT) begin
      return 12'(base + 12'(w[7:0]));
    end else if (w[7:0] < balu_pkg::ACC_SPLIT) begin
      return {balu_pkg::ACC_LO_PAGE, w[7:0]};
    end else begin
      return {balu_pkg::ACC_HI_PAGE, w[7:0]};
    end
  endfunction

  // read value of a register offset
  function automatic logic [31:0] f_rd(input balu_core_state_t t, input logic [7:0] a);
    if (a == balu_pkg::REG_CTRL) begin
      return {30'h0, t.ext, t.run};
    end else if (a == balu_pkg::REG_WORK) begin
      return {24'h0, t.working_register};
    end else if (a == balu_pkg::REG_STATUS) begin
      return {27'h0, t.flags};
    end else if (a == balu_pkg::REG_BANK) begin
      return {28'h0, t.bank_select_register};
    end else if (a == balu_pkg::REG_PC) begin
      return {11'h0, t.pc};
    end else if (a == balu_pkg::REG_INDEX) begin
      return {20'h0, t.fsr2};
    end else begin
      return {16'h0, t.ir};
    end
  endfunction

  // offset is one of the mapped words
  function automatic logic f_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && a <= balu_pkg::REG_INSTR;
  endfunction

  // arithmetic on working register and operand
  balu_alu u_alu (
    .op_i     (f_aluop(s.ir)),
    .bitsel_i (s.ir[11:9]),
    .a_i      (s.working_register),
    .b_i      (s.opnd),
    .cin_i    (s.flags[balu_pkg::FLG_C]),
    .res_o    (alu_res),
    .flags_o  (alu_flg)
  );

  // next state: bus slave first, core afterwards so hardware wins
  always_comb begin
    n = s;
    n.dwr = 1'b0;
    // write address and data taken in either order
    if (s_axi_awvalid_i && s.awready) begin
      n.aw_got  = 1'b1;
      n.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s.wready) begin
      n.w_got = 1'b1;
      n.wdata = s_axi_wdata_i;
      n.wstrb = s_axi_wstrb_i;
    end
    // both held: perform the write and answer
    if (s.aw_got && s.w_got) begin
      n.aw_got = 1'b0;
      n.w_got  = 1'b0;
      n.bvalid = 1'b1;
      n.bresp  = f_mapped(s.aw_addr) && s.aw_addr != balu_pkg::REG_INSTR
               ? balu_pkg::RESP_OKAY : balu_pkg::RESP_SLVERR;
      if (s.wstrb[0]) begin
        if (s.aw_addr == balu_pkg::REG_CTRL) begin
          n.run = s.wdata[0];
          n.ext = s.wdata[1];
        end else if (s.aw_addr == balu_pkg::REG_WORK) begin
          n.working_register = s.wdata[7:0];
        end else if (s.aw_addr == balu_pkg::REG_STATUS) begin
          n.flags = s.wdata[4:0];
        end else if (s.aw_addr == balu_pkg::REG_BANK) begin
          n.bank_select_register = s.wdata[3:0];
        end else if (s.aw_addr == balu_pkg::REG_PC) begin
          n.pc = s.wdata[20:0];
        end else if (s.aw_addr == balu_pkg::REG_INDEX) begin
          n.fsr2 = s.wdata[11:0];
        end
      end
    end
    // response held until accepted
    if (s.bvalid && s_axi_bready_i) begin
      n.bvalid = 1'b0;
    end
    n.awready = !n.aw_got && !n.bvalid;
    n.wready  = !n.w_got && !n.bvalid;
    // read answered one cycle after the address
    if (s_axi_arvalid_i && s.arready) begin
      n.rvalid = 1'b1;
      n.rdata  = f_mapped(s_axi_araddr_i) ? f_rd(s, s_axi_araddr_i) : 32'h0;
      n.rresp  = f_mapped(s_axi_araddr_i) ? balu_pkg::RESP_OKAY : balu_pkg::RESP_SLVERR;
    end
    if (s.rvalid && s_axi_rready_i) begin
      n.rvalid = 1'b0;
    end
    n.arready = !n.rvalid;
    // quarter sequencer, stands still while halted
    if (s.run) begin
      case (s.q)
        balu_pkg::BALU_Q1: begin
          n.q = balu_pkg::BALU_Q2;
          if (!s.nop) begin
            n.ir    = instr_i;
            n.pcinc = s.pc + balu_pkg::PC_STEP;
            n.daddr = f_addr(instr_i, s.bank_select_register, s.ext, s.fsr2);
            n.drd   = f_file(instr_i);
          end
        end
        balu_pkg::BALU_Q2: begin
          n.q   = balu_pkg::BALU_Q3;
          n.drd = 1'b0;
          n.opnd = f_file(s.ir) ? dmem_rdata_i : s.ir[7:0];
        end
        balu_pkg::BALU_Q3: begin
          n.q     = balu_pkg::BALU_Q4;
          n.res   = alu_res;
          n.rflag = alu_flg;
        end
        default: begin
          n.q = balu_pkg::BALU_Q1;
          if (s.nop) begin
            n.nop = 1'b0;
          end else begin
            n.pc = s.pcinc;
            n.flags = (s.flags & ~f_fmask(s.ir)) | (s.rflag & f_fmask(s.ir));
            if (f_lit(s.ir) || (f_fop(s.ir) && !s.ir[balu_pkg::BIT_DEST])) begin
              n.working_register = s.res;
            end else if (f_file(s.ir)) begin
              n.dwr    = 1'b1;
              n.dwdata = s.res;
            end
            if (s.ir[15:8] == balu_pkg::OPC_BR_CARRY && s.flags[balu_pkg::FLG_C]) begin
              n.pc  = s.pcinc + {{12{s.ir[7]}}, s.ir[7:0], 1'b0};
              n.nop = 1'b1;
            end
          end
        end
      endcase
    end
  end

  // state register, synchronous reset
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // outputs straight from state
  assign pc_o            = s.pc;
  assign dmem_addr_o     = s.daddr;
  assign dmem_rd_o       = s.drd;
  assign dmem_wr_o       = s.dwr;
  assign dmem_wdata_o    = s.dwdata;
  assign s_axi_awready_o = s.awready;
  assign s_axi_wready_o  = s.wready;
  assign s_axi_bresp_o   = s.bresp;
  assign s_axi_bvalid_o  = s.bvalid;
  assign s_axi_arready_o = s.arready;
  assign s_axi_rdata_o   = s.rdata;
  assign s_axi_rresp_o   = s.rresp;
  assign s_axi_rvalid_o  = s.rvalid;

  // checks on the datapath, sequencer and write response
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);

  // write-back quarter of a real instruction
  sequence wb_q4;
    s.run && s.q == balu_pkg::BALU_Q4 && !s.nop;
  endsequence
  // taken carry branch at write-back
  sequence br_taken;
    wb_q4 ##0 (s.ir[15:8] == balu_pkg::OPC_BR_CARRY && s.flags[balu_pkg::FLG_C]);
  endsequence

  lit_add_a: assert property (
    wb_q4 ##0 s.ir[15:8] == balu_pkg::OPC_ADD_LIT
    |=> s.working_register == 8'($past(s.opnd) + $past(s.working_register)))
    else $error("literal add result wrong");
  file_add_a: assert property (
    wb_q4 ##0 (s.ir[15:10] == balu_pkg::OPC_ADD_FILE && s.ir[9])
    |=> dmem_wr_o && dmem_wdata_o == 8'($past(s.opnd) + $past(s.working_register)))
    else $error("file add write wrong");
  dest_work_a: assert property (
    wb_q4 ##0 (f_fop(s.ir) && !s.ir[9]) |=> !dmem_wr_o && s.working_register == $past(s.res))
    else $error("working destination wrong");
  bank_addr_a: assert property (
    s.q == balu_pkg::BALU_Q2 && s.drd && s.ir[8] |-> s.daddr == {$past(s.bank_select_register), s.ir[7:0]})
    else $error("banked address wrong");
  index_addr_a: assert property (
    s.q == balu_pkg::BALU_Q2 && s.drd && !s.ir[8] && $past(s.ext) && s.ir[7:0] <= 8'h5f
    |-> s.daddr == 12'($past(s.fsr2) + 12'(s.ir[7:0])))
    else $error("indexed address wrong");
  addc_carry_a: assert property (
    wb_q4 ##0 s.ir[15:10] == balu_pkg::OPC_ADDC_FIL
    |=> s.flags[0] == 1'((9'($past(s.working_register)) + 9'($past(s.opnd)) + 9'($past(s.flags[0]))) >> 8))
    else $error("add with carry flag wrong");
  and_flags_a: assert property (
    wb_q4 ##0 f_aluop(s.ir) == balu_pkg::BALU_AND
    |=> s.flags[3] == $past(s.flags[3]) && s.flags[1:0] == $past(s.flags[1:0])
        && s.flags[2] == ($past(s.res) == 8'h00))
    else $error("logic flags wrong");
  branch_tgt_a: assert property (
    br_taken |=> s.flags == $past(s.flags)
    && s.pc == $past(s.pcinc) + {{12{$past(s.ir[7])}}, $past(s.ir[7:0]), 1'b0})
    else $error("branch target wrong");
  no_branch_a: assert property (
    wb_q4 ##0 (s.ir[15:8] == balu_pkg::OPC_BR_CARRY && !s.flags[0])
    |=> s.pc == $past(s.pcinc) && !s.nop)
    else $error("untaken branch wrong");
  taken_nop_a: assert property (
    br_taken |=> s.nop && s.q == balu_pkg::BALU_Q1 && !dmem_wr_o)
    else $error("no second cycle after branch");
  nop_quiet_a: assert property (
    s.nop && s.q != balu_pkg::BALU_Q1 |-> !s.drd && !s.dwr)
    else $error("activity in no-operation cycle");
  clear_bit_a: assert property (
    wb_q4 ##0 s.ir[15:12] == balu_pkg::OPC_CLR_BIT
    |=> dmem_wr_o && s.flags == $past(s.flags)
        && dmem_wdata_o == ($past(s.opnd) & ~(8'h01 << $past(s.ir[11:9]))))
    else $error("bit clear wrong");
  zero_neg_a: assert property (
    wb_q4 ##0 f_fmask(s.ir) == 5'h1f
    |=> s.flags[4] == $past(s.res[7]) && s.flags[2] == ($past(s.res) == 8'h00))
    else $error("negative or zero flag wrong");
  phase_seq_a: assert property (
    (s.run && s.q == balu_pkg::BALU_Q1) ##1 s.run[*2] |=> s.q == balu_pkg::BALU_Q4)
    else $error("quarter sequence broken");
  bresp_hold_a: assert property (
    s.bvalid && !s_axi_bready_i |=> s.bvalid && $stable(s.bresp))
    else $error("write response dropped");

endmodule // balu_core

// *** tb/balu_mem_model.sv ***
// fetch and banked data memory seen from the core
module balu_mem_model (
  // clock
  input  wire logic        ref_clk_i,
  // fetch side
  input  wire logic [20:0] pc_i,
  output logic      [15:0] instr_o,
  // data side
  input  wire logic [11:0] addr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wdata_i
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] imem [0:255];   // program words
  logic [7:0]  dmem [0:4095];  // data bytes
  logic [7:0]  last = 8'h00;   // last byte driven
  // counter is a byte address, one word every two bytes
  assign instr_o = imem[pc_i[8:1]];
  // released data lines show the inverse of the last byte, not a stale copy
  assign rdata_o = rd_i ? dmem[addr_i] : ~last;
  // write pulse stores, a read remembers what it drove
  always @(posedge ref_clk_i) begin
    if (wr_i) dmem[addr_i] <= wdata_i;
    if (rd_i) last <= dmem[addr_i];
  end
endmodule // balu_mem_model

// *** tb/test_byte_alu_branch_subset.sv ***
// self-checking bench for the subset core
module test_byte_alu_branch_subset;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0;       // core clock
  logic        rst_n = 1'b0;     // synchronous reset
  logic [15:0] instr;            // fetched word
  logic [20:0] pc;               // fetch address
  logic [11:0] daddr;            // data address
  logic        drd;              // data read
  logic [7:0]  drdata;           // data read value
  logic        dwr;              // data write pulse
  logic [7:0]  dwdata;           // data write value
  logic [7:0]  awaddr = 8'h00;   // write address
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;    // write data
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;   // read address
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  int          n_mismatch = 0;   // failed comparisons
  int          cmp_count = 0;    // all comparisons
  int          cyc = 0;          // timeout counter
  // program, one word per two bytes of counter
  localparam logic [15:0] PROG [0:15] = '{16'h0fff, 16'he205, 16'h0, 16'h0, 16'h0, 16'h0,
    16'h0, 16'h0f17, 16'h2620, 16'h1730, 16'h2340, 16'h0b0f, 16'h9e50, 16'he27f,
    16'h2480, 16'h0f78};

  // device under test
  balu_core uut (.ref_clk_i(clk), .rst_n_i(rst_n), .instr_i(instr), .pc_o(pc),
    .dmem_addr_o(daddr), .dmem_rd_o(drd), .dmem_rdata_i(drdata), .dmem_wr_o(dwr),
    .dmem_wdata_o(dwdata), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready));
  // memories on the far side
  balu_mem_model mdl (.ref_clk_i(clk), .pc_i(pc), .instr_o(instr), .addr_i(daddr),
    .rd_i(drd), .rdata_o(drdata), .wr_i(dwr), .wdata_i(dwdata));

  // clock, 40 ns period
  initial begin
    forever #20 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // compare and count
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // one write, address and data offered together; late holds bready back a while
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input bit late,
                        output logic [1:0] r);
    logic awd;
    logic wd;
    awd = 1'b0;
    wd = 1'b0;
    @(posedge clk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= !late;
    while (!(awd && wd)) begin
      @(posedge clk);
      if (!awd && awready) begin
        awd = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready) begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(posedge clk); while (!bvalid);
    // response must stand while the master is not ready
    if (late) begin
      repeat (2) @(posedge clk);
      check("response stands", {31'h0, bvalid}, 32'h1);
      bready <= 1'b1;
      @(posedge clk);
    end
    r = bresp;
    bready <= 1'b0;
  endtask
  // one read
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge clk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  // write ignoring the answer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_wr(a, d, 1'b0, r);
  endtask
  // read a register and compare
  task automatic reg_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(a, d, r);
    check(nm, d, exp);
  endtask
  // clocks until the counter shows a value
  task automatic wait_pc(input logic [20:0] t, output int n);
    n = 0;
    while (pc !== t) begin
      @(posedge clk);
      n++;
    end
  endtask

  // reset values and bus refusals
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    reg_chk("pc reset", balu_pkg::REG_PC, 32'h0);
    wr(balu_pkg::REG_WORK, 32'h01);
    reg_chk("work rw", balu_pkg::REG_WORK, 32'h01);
    axi_rd(8'h1c, d, r);
    check("unmapped resp", {30'h0, r}, {30'h0, balu_pkg::RESP_SLVERR});
    check("unmapped data", d, 32'h0);
    axi_wr(balu_pkg::REG_INSTR, 32'h1234, 1'b1, r);
    check("ro write resp", {30'h0, r}, {30'h0, balu_pkg::RESP_SLVERR});
    $display("regs test done");
  endtask
  // program through every operation and both branch outcomes
  task automatic t_prog;
    int n;
    for (int i = 0; i < 16; i++) mdl.imem[i] = PROG[i];
    mdl.dmem[12'h020] = 8'hf0;
    mdl.dmem[12'h230] = 8'hc2;
    mdl.dmem[12'h240] = 8'h4d;
    mdl.dmem[12'h050] = 8'hc7;
    mdl.dmem[12'hf80] = 8'h01;
    wr(balu_pkg::REG_BANK, 32'h2);
    wr(balu_pkg::REG_STATUS, 32'h0);
    wr(balu_pkg::REG_CTRL, 32'h1);
    wait_pc(21'd14, n);
    wait_pc(21'd16, n);
    check("taken cycles", 32'(n), 32'd8);
    wait_pc(21'd26, n);
    wait_pc(21'd28, n);
    check("not taken cycles", 32'(n), 32'd4);
    wait_pc(21'd32, n);
    wr(balu_pkg::REG_CTRL, 32'h0);
    check("add file", {24'h0, mdl.dmem[12'h020]}, 32'h07);
    check("and file", {24'h0, mdl.dmem[12'h230]}, 32'h02);
    check("add carry", {24'h0, mdl.dmem[12'h240]}, 32'h65);
    check("bit clear", {24'h0, mdl.dmem[12'h050]}, 32'h47);
    reg_chk("work end", balu_pkg::REG_WORK, 32'h80);
    reg_chk("status end", balu_pkg::REG_STATUS, 32'h1a);
    $display("program test done");
  endtask
  // extended set uses the indexed base for low addresses, then a backward carry branch
  task automatic t_ext;
    int n;
    mdl.imem[8'h20] = 16'h2610;
    mdl.imem[8'h21] = 16'h0f80;
    mdl.imem[8'h22] = 16'he2fc;
    mdl.dmem[12'h310] = 8'h05;
    wr(balu_pkg::REG_INDEX, 32'h300);
    wr(balu_pkg::REG_PC, 32'h40);
    wr(balu_pkg::REG_CTRL, 32'h3);
    wait_pc(21'h3e, n);
    wr(balu_pkg::REG_CTRL, 32'h0);
    check("back branch", 32'(pc), 32'h3e);
    check("indexed add", {24'h0, mdl.dmem[12'h310]}, 32'h85);
    check("access untouched", {24'h0, mdl.dmem[12'h010]}, 32'h00);
    reg_chk("work ext", balu_pkg::REG_WORK, 32'h00);
    reg_chk("status ext", balu_pkg::REG_STATUS, 32'h0d);
    $display("extended test done");
  endtask
  // verdict and end of run
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    for (int i = 0; i < 256; i++) mdl.imem[i] = 16'h0;
    for (int i = 0; i < 4096; i++) mdl.dmem[i] = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_prog();
    t_ext();
    stop_test();
  end
endmodule // test_byte_alu_branch_subset
